/* status_reporting_unit.sv */
`timescale 1ns/1ns
`include "status_reporting_defs.svh"


module status_reporting_unit (
  // Clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      rstn_in,
  // Supply status pins
  input  wire logic                      settling_in,
  input  wire logic                      trig_enabled_in,
  input  wire logic                      trig_external_in,
  input  wire logic                      trig_pin_in,
  input  wire logic                      trans_armed_in,
  input  wire logic                      trans_done_in,
  input  wire logic                      const_volt_in,
  input  wire logic                      const_curr_in,
  input  wire logic                      sample_done_in,
  input  wire logic                      list_done_in,
  input  wire logic                      list_running_in,
  input  wire logic                      thermal_fault_in,
  input  wire logic                      slave_fault_in,
  input  wire logic                      volt_prot_in,
  input  wire logic                      curr_prot_in,
  input  wire logic                      sinking_in,
  // Parser side status
  input  wire status_reporting_pkg::byte_t std_cond_in,
  input  wire logic                      err_queue_nonempty_in,
  input  wire logic                      reply_avail_in,
  // Register access port
  input  wire status_reporting_pkg::sel_t  acc_sel_in,
  input  wire logic                      acc_wr_in,
  input  wire logic                      acc_rd_in,
  input  wire status_reporting_pkg::word_t acc_wdata_in,
  output      status_reporting_pkg::word_t acc_rdata_out,
  output      logic                      acc_rvalid_out,
  // Host bus side
  output      status_reporting_pkg::byte_t status_byte_out,
  output      logic                      srq_out
);
  import status_reporting_pkg::*;

  // ==========================================================
  // Pin synchronisers

  localparam int PIN_W = 16;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;

  // Gather the asynchronous pins into one vector
  assign pin_raw = {settling_in, trig_enabled_in, trig_external_in,
                    trig_pin_in, trans_armed_in, trans_done_in,
                    const_volt_in, const_curr_in, sample_done_in,
                    list_done_in, list_running_in, thermal_fault_in,
                    slave_fault_in, volt_prot_in, curr_prot_in,
                    sinking_in};

  // Two stages; only the second stage is read by logic
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  logic s_settling, s_trig_en, s_trig_ext, s_trig_pin, s_armed;
  logic s_tdone, s_cv, s_cc, s_sample, s_ldone, s_lrun;
  logic s_thermal, s_slave, s_vprot, s_cprot, s_sink;

  assign {s_settling, s_trig_en, s_trig_ext, s_trig_pin, s_armed,
          s_tdone, s_cv, s_cc, s_sample, s_ldone, s_lrun,
          s_thermal, s_slave, s_vprot, s_cprot, s_sink} = pin_sync;

  // ==========================================================
  // Trigger wait flag

  logic trigger_wait_flag;

  // External source holds the flag while the trigger pin is low
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      trigger_wait_flag <= 1'b0;
    end else begin
      trigger_wait_flag <= s_trig_en |
                           (trigger_wait_flag & s_trig_ext & ~s_trig_pin);
    end
  end

  // ==========================================================
  // Condition vectors

  word_t next_oper_cond;
  word_t next_ques_cond;

  // Unassigned positions stay zero
  always_comb begin
    next_oper_cond = `WORD_RESET;
    next_oper_cond[`OPER_SETTLING]   = s_settling;
    next_oper_cond[`OPER_WAIT_TRIG]  = trigger_wait_flag;
    next_oper_cond[`OPER_TRANS_ARM]  = s_armed;
    next_oper_cond[`OPER_LIST_RUN]   = s_lrun;
    next_oper_cond[`OPER_CONST_V]    = s_cv;
    next_oper_cond[`OPER_CONST_C]    = s_cc;
    next_oper_cond[`OPER_TRANS_DONE] = s_tdone;
    next_oper_cond[`OPER_LIST_DONE]  = s_ldone;
    next_oper_cond[`OPER_SAMPLE]     = s_sample;
  end

  always_comb begin
    next_ques_cond = `WORD_RESET;
    next_ques_cond[`QUES_CURR_MODE] = s_cc;
    next_ques_cond[`QUES_VOLT_MODE] = s_cv;
    next_ques_cond[`QUES_THERMAL]   = s_thermal;
    next_ques_cond[`QUES_SLAVE]     = s_slave;
    next_ques_cond[`QUES_VPROT]     = s_vprot;
    next_ques_cond[`QUES_CPROT]     = s_cprot;
    next_ques_cond[`QUES_SINK]      = s_sink;
  end

  // ==========================================================
  // Condition registers

  word_t oper_cond;
  word_t ques_cond;
  byte_t std_cond;
  byte_t stb_cond;
  byte_t next_stb_cond;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      oper_cond <= `WORD_RESET;
      ques_cond <= `WORD_RESET;
      std_cond  <= `BYTE_RESET;
      stb_cond  <= `BYTE_RESET;
    end else begin
      oper_cond <= next_oper_cond;
      ques_cond <= next_ques_cond;
      std_cond  <= std_cond_in;
      stb_cond  <= next_stb_cond;
    end
  end

  // ==========================================================
  // Access decode

  logic rd_oper_ev, rd_ques_ev, rd_std_ev, rd_stb_ev;

  assign rd_oper_ev = acc_rd_in && (acc_sel_in == `SEL_OPER_EVENT);
  assign rd_ques_ev = acc_rd_in && (acc_sel_in == `SEL_QUES_EVENT);
  assign rd_std_ev  = acc_rd_in && (acc_sel_in == `SEL_STD_EVENT);
  assign rd_stb_ev  = acc_rd_in && (acc_sel_in == `SEL_STB_EVENT);

  // ==========================================================
  // Event registers

  word_t oper_event;
  word_t ques_event;
  byte_t std_event;
  byte_t stb_event;

  // A rise in the reading cycle survives the clear
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      oper_event <= `WORD_RESET;
      ques_event <= `WORD_RESET;
      std_event  <= `BYTE_RESET;
      stb_event  <= `BYTE_RESET;
    end else begin
      oper_event <= (oper_event & ~{16{rd_oper_ev}}) |
                    (next_oper_cond & ~oper_cond);
      ques_event <= (ques_event & ~{16{rd_ques_ev}}) |
                    (next_ques_cond & ~ques_cond);
      std_event  <= (std_event & ~{8{rd_std_ev}}) |
                    (std_cond_in & ~std_cond);
      stb_event  <= (stb_event & ~{8{rd_stb_ev}}) |
                    (next_stb_cond & ~stb_cond);
    end
  end

  // ==========================================================
  // Enable registers

  word_t oper_enable;
  word_t ques_enable;
  byte_t std_enable;
  byte_t srq_enable;

  // Only the enables are writable; other selects ignore writes
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      oper_enable <= `WORD_RESET;
      ques_enable <= `WORD_RESET;
      std_enable  <= `BYTE_RESET;
      srq_enable  <= `BYTE_RESET;
    end else if (acc_wr_in) begin
      unique case (acc_sel_in)
        `SEL_OPER_ENABLE: oper_enable <= acc_wdata_in;
        `SEL_QUES_ENABLE: ques_enable <= acc_wdata_in;
        `SEL_STD_ENABLE:  std_enable  <= acc_wdata_in[7:0];
        `SEL_SRQ_ENABLE:  srq_enable  <= acc_wdata_in[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Summaries and status byte

  logic oper_sum;
  logic ques_sum;
  logic std_sum;
  logic rqs_sum;

  assign oper_sum = |(oper_event & oper_enable);
  assign ques_sum = |(ques_event & ques_enable);
  assign std_sum  = |(std_event & std_enable);

  // Bit 3 low only when no error queued and no questionable summary
  always_comb begin
    next_stb_cond = `BYTE_RESET;
    next_stb_cond[`STB_QUES_SUM]  = ques_sum | err_queue_nonempty_in;
    next_stb_cond[`STB_MSG_AVAIL] = reply_avail_in;
    next_stb_cond[`STB_STD_SUM]   = std_sum;
    next_stb_cond[`STB_OPER_SUM]  = oper_sum;
    next_stb_cond[`STB_RQS]       = 1'b0;
  end

  // Bit 6 excluded from its own term to avoid a feedback loop
  assign rqs_sum = |(next_stb_cond & srq_enable & `STB_RQS_MASK);

  // ==========================================================
  // Host bus outputs

  // Registered: the line trails the summary by one cycle
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      status_byte_out <= `BYTE_RESET;
      srq_out         <= 1'b0;
    end else begin
      status_byte_out <= next_stb_cond | ({7'h00, rqs_sum} << `STB_RQS);
      srq_out         <= rqs_sum;
    end
  end

  // ==========================================================
  // Read data

  word_t rd_value;
  byte_t stb_view;

  assign stb_view = stb_cond | ({7'h00, srq_out} << `STB_RQS);

  // Unmapped selects read as zero
  always_comb begin
    rd_value = `WORD_RESET;
    unique case (acc_sel_in)
      `SEL_OPER_COND:   rd_value = oper_cond & ~`OPER_HIDE_MASK;
      `SEL_OPER_EVENT:  rd_value = oper_event;
      `SEL_OPER_ENABLE: rd_value = oper_enable;
      `SEL_QUES_COND:   rd_value = ques_cond;
      `SEL_QUES_EVENT:  rd_value = ques_event;
      `SEL_QUES_ENABLE: rd_value = ques_enable;
      `SEL_STD_COND:    rd_value = {8'h00, std_cond};
      `SEL_STD_EVENT:   rd_value = {8'h00, std_event};
      `SEL_STD_ENABLE:  rd_value = {8'h00, std_enable};
      `SEL_STB:         rd_value = {8'h00, stb_view};
      `SEL_STB_EVENT:   rd_value = {8'h00, stb_event};
      `SEL_SRQ_ENABLE:  rd_value = {8'h00, srq_enable};
      default:          rd_value = `WORD_RESET;
    endcase
  end

  // Data is held until the next read
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      acc_rdata_out  <= `WORD_RESET;
      acc_rvalid_out <= 1'b0;
    end else begin
      acc_rvalid_out <= acc_rd_in;
      if (acc_rd_in) begin
        acc_rdata_out <= rd_value;
      end
    end
  end

endmodule

/* status_reporting_defs.svh */
`ifndef STATUS_REPORTING_DEFS_SVH
`define STATUS_REPORTING_DEFS_SVH

// ==========================================================
// Access select codes
`define SEL_OPER_COND   4'h0
`define SEL_OPER_EVENT  4'h1
`define SEL_OPER_ENABLE 4'h2
`define SEL_QUES_COND   4'h3
`define SEL_QUES_EVENT  4'h4
`define SEL_QUES_ENABLE 4'h5
`define SEL_STD_COND    4'h6
`define SEL_STD_EVENT   4'h7
`define SEL_STD_ENABLE  4'h8
`define SEL_STB         4'h9
`define SEL_STB_EVENT   4'ha
`define SEL_SRQ_ENABLE  4'hb

// ==========================================================
// Operation bit positions
`define OPER_SETTLING   1
`define OPER_WAIT_TRIG  5
`define OPER_TRANS_ARM  6
`define OPER_CONST_V    8
`define OPER_TRANS_DONE 9
`define OPER_CONST_C    10
`define OPER_SAMPLE     11
`define OPER_LIST_DONE  12
`define OPER_LIST_RUN   14

// Operation bits that read as zero in the condition register
`define OPER_HIDE_MASK  16'h1200

// ==========================================================
// Questionable bit positions
`define QUES_CURR_MODE  0
`define QUES_VOLT_MODE  1
`define QUES_THERMAL    3
`define QUES_SLAVE      6
`define QUES_VPROT      12
`define QUES_CPROT      13
`define QUES_SINK       14

// ==========================================================
// Status byte bit positions
`define STB_QUES_SUM    3
`define STB_MSG_AVAIL   4
`define STB_STD_SUM     5
`define STB_RQS         6
`define STB_OPER_SUM    7
`define STB_RQS_MASK    8'hbf

// ==========================================================
// Reset values
`define WORD_RESET      16'h0000
`define BYTE_RESET      8'h00

`endif

/* status_reporting_pkg.sv */
// ==========================================================
// Shared types
package status_reporting_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;
  typedef logic [3:0]  sel_t;
endpackage

/* status_reporting_checker.sv */
`timescale 1ns/1ns
`include "status_reporting_defs.svh"
// ==========================================================
// Port checks on the status unit
module status_reporting_checker
  import status_reporting_pkg::*;
(
  // Observed ports
  input wire logic  mclk_in,
  input wire logic  rstn_in,
  input wire logic  err_queue_nonempty_in,
  input wire logic  reply_avail_in,
  input wire sel_t  acc_sel_in,
  input wire logic  acc_rd_in,
  input wire word_t acc_rdata_out,
  input wire logic  acc_rvalid_out,
  input wire byte_t status_byte_out,
  input wire logic  srq_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  // Read handshake and read data shape
  AST_RVALID: assert property (acc_rd_in |=> acc_rvalid_out)
    else $error("read not answered");
  AST_NO_RVALID: assert property (!acc_rd_in |=> !acc_rvalid_out)
    else $error("spurious read valid");
  AST_OP_ZERO: assert property (acc_rd_in && acc_sel_in == `SEL_OPER_COND |=>
    (acc_rdata_out & 16'hb29d) == 16'h0000) else $error("dead operation bit set");
  AST_QUES_ZERO: assert property (acc_rd_in && acc_sel_in == `SEL_QUES_COND |=>
    (acc_rdata_out & 16'h8fb4) == 16'h0000) else $error("dead questionable bit set");
  AST_BYTE_WIDTH: assert property (acc_rd_in && acc_sel_in >= `SEL_STD_COND |=>
    acc_rdata_out[15:8] == 8'h00) else $error("byte register upper half set");

  // Status byte and request line; the first edge after reset has no history
  AST_SRQ_BIT6: assert property (srq_out == status_byte_out[`STB_RQS])
    else $error("request line differs from bit 6");
  AST_MSG_BIT: assert property ($past(rstn_in) |->
    status_byte_out[`STB_MSG_AVAIL] == $past(reply_avail_in)) else $error("bit 4 wrong");
  AST_QUEUE_BIT: assert property (err_queue_nonempty_in |=>
    status_byte_out[`STB_QUES_SUM]) else $error("queue did not set bit 3");

  // Main scenarios
  COV_SRQ: cover property ($rose(srq_out));
  COV_DROP: cover property ($fell(srq_out));
  COV_MSG: cover property (reply_avail_in ##1 status_byte_out[`STB_MSG_AVAIL]);
endmodule

bind status_reporting_unit status_reporting_checker status_reporting_checker_i (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .err_queue_nonempty_in(err_queue_nonempty_in),
  .reply_avail_in(reply_avail_in), .acc_sel_in(acc_sel_in), .acc_rd_in(acc_rd_in),
  .acc_rdata_out(acc_rdata_out), .acc_rvalid_out(acc_rvalid_out),
  .status_byte_out(status_byte_out), .srq_out(srq_out));

/* host_poll_model.sv */
`timescale 1ns/1ns
// ==========================================================
// Host controller that serial-polls on each fresh request
module host_poll_model
  import status_reporting_pkg::*;
(
  // Host bus view
  input  wire logic  mclk_in,
  input  wire logic  srq_in,
  input  wire byte_t status_byte_in,
  // Last poll response
  output byte_t      polled_out = 8'h00
);
  logic srq_q = 1'b0;

  // A held request is polled once only, as a real controller would
  always_ff @(posedge mclk_in) begin
    srq_q <= srq_in;
    if (srq_in && !srq_q) begin
      polled_out <= status_byte_in;
    end
  end
endmodule

/* status_reporting_unit_tb.sv */
`timescale 1ns/1ns
`include "status_reporting_defs.svh"
// ==========================================================
// Testbench
module status_reporting_unit_tb;
  import status_reporting_pkg::*;
  logic  mclk_in = 1'b0;
  logic  rstn_in = 1'b0;
  logic  [15:0] pins = 16'h0000;
  logic  err_q = 1'b0, reply = 1'b0, rd = 1'b0, wr = 1'b0;
  sel_t  sel = 4'h0;
  word_t wdata = 16'h0000, rdata;
  logic  rvalid, srq;
  byte_t sbyte, polled;
  byte_t std_in = 8'h00;
  int    failures = 0, checks = 0;
  sel_t  ens[4] = '{4'h2, 4'h5, 4'h8, 4'hb};
  // Expected bits per pin index
  word_t op_tab[16] = '{16'h2, 16'h20, 16'h0, 16'h0, 16'h40, 16'h200, 16'h100, 16'h400,
                        16'h800, 16'h1000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  word_t q_tab[16] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h2, 16'h1,
                       16'h0, 16'h0, 16'h0, 16'h8, 16'h40, 16'h1000, 16'h2000, 16'h4000};

  // Clock
  always #20 mclk_in = ~mclk_in;

  status_reporting_unit status_reporting_unit_i (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .settling_in(pins[0]), .trig_enabled_in(pins[1]),
    .trig_external_in(pins[2]), .trig_pin_in(pins[3]), .trans_armed_in(pins[4]),
    .trans_done_in(pins[5]), .const_volt_in(pins[6]), .const_curr_in(pins[7]),
    .sample_done_in(pins[8]), .list_done_in(pins[9]), .list_running_in(pins[10]),
    .thermal_fault_in(pins[11]), .slave_fault_in(pins[12]), .volt_prot_in(pins[13]),
    .curr_prot_in(pins[14]), .sinking_in(pins[15]), .std_cond_in(std_in),
    .err_queue_nonempty_in(err_q), .reply_avail_in(reply), .acc_sel_in(sel),
    .acc_wr_in(wr), .acc_rd_in(rd), .acc_wdata_in(wdata), .acc_rdata_out(rdata),
    .acc_rvalid_out(rvalid), .status_byte_out(sbyte), .srq_out(srq));

  host_poll_model host_poll_model_i (
    .mclk_in(mclk_in), .srq_in(srq), .status_byte_in(sbyte), .polled_out(polled));

  // Inputs always change 1 ns after a rising edge
  task tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task close_out();
    $display("Counts: checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input word_t got, input word_t exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Trailing idle cycle keeps a strobe from being set twice in one step
  task wr_reg(input sel_t s, input word_t d);
    sel = s;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask

  task rd_reg(input sel_t s, input word_t exp);
    int n;
    sel = s;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++) tick(1);
    // A missing answer ends the run through the common verdict
    if (n == 4) begin
      failures++;
      close_out();
    end else begin
      chk(rdata, exp);
      tick(1);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    tick(20);
    rstn_in = 1'b1;
    // Everything clear after reset, unmapped select too
    for (int i = 0; i < 13; i++) rd_reg(sel_t'(i), 16'h0);
    // Enables read back; byte-wide ones keep the low half only
    foreach (ens[i]) begin
      wr_reg(ens[i], 16'ha5c3);
      rd_reg(ens[i], ens[i] >= 4'h8 ? 16'h00c3 : 16'ha5c3);
      wr_reg(ens[i], 16'h0);
    end
    wr_reg(`SEL_OPER_COND, 16'hffff);
    rd_reg(`SEL_OPER_COND, 16'h0);
    // Each pin reaches its condition and event bits; reads clear events
    for (int i = 0; i < 16; i++) begin
      pins[i] = 1'b1;
      tick(4);
      rd_reg(`SEL_OPER_COND, op_tab[i] & ~`OPER_HIDE_MASK);
      rd_reg(`SEL_QUES_COND, q_tab[i]);
      rd_reg(`SEL_OPER_EVENT, op_tab[i]);
      rd_reg(`SEL_QUES_EVENT, q_tab[i]);
      rd_reg(`SEL_OPER_EVENT, 16'h0);
      pins[i] = 1'b0;
      tick(4);
      rd_reg(`SEL_QUES_EVENT, 16'h0);
    end
    // Trigger flag held by an external source until its pin returns high
    pins[2:1] = 2'b11;
    tick(4);
    pins[1] = 1'b0;
    tick(4);
    rd_reg(`SEL_OPER_COND, 16'h0020);
    pins[3] = 1'b1;
    tick(4);
    rd_reg(`SEL_OPER_COND, 16'h0);
    pins[3:2] = 2'b00;
    rd_reg(`SEL_OPER_EVENT, 16'h0020);
    // Only enabled questionable events reach bit 3 and the request
    wr_reg(`SEL_QUES_ENABLE, 16'h0008);
    wr_reg(`SEL_SRQ_ENABLE, 16'h0008);
    pins[12] = 1'b1;
    tick(5);
    chk({15'h0, srq}, 16'h0);
    pins[11] = 1'b1;
    tick(5);
    chk({8'h00, sbyte}, 16'h0048);
    chk({8'h00, polled}, 16'h0048);
    rd_reg(`SEL_QUES_EVENT, 16'h0048);
    chk({7'h0, srq, sbyte}, 16'h0);
    // Enabled standard events reach bit 5 and, when bit 5 is enabled, the request
    std_in = 8'h21;
    tick(3);
    rd_reg(`SEL_STD_COND, 16'h0021);
    wr_reg(`SEL_STD_ENABLE, 16'h0001);
    wr_reg(`SEL_SRQ_ENABLE, 16'h0020);
    tick(1);
    chk({7'h0, srq, sbyte}, 16'h0160);
    rd_reg(`SEL_STB, 16'h0060);
    // Bit 3 rose earlier in the questionable scenario and is still latched
    rd_reg(`SEL_STB_EVENT, 16'h0028);
    rd_reg(`SEL_STD_EVENT, 16'h0021);
    chk({7'h0, srq, sbyte}, 16'h0000);
    // Enabled operation event reaches bit 7; bit 7 is not in the request enable
    wr_reg(`SEL_OPER_ENABLE, 16'h0002);
    pins[0] = 1'b1;
    tick(5);
    chk({7'h0, srq, sbyte}, 16'h0080);
    rd_reg(`SEL_OPER_EVENT, 16'h0002);
    wr_reg(`SEL_SRQ_ENABLE, 16'h0008);
    // Queue and reply bits; bit 6 never feeds itself
    err_q = 1'b1;
    reply = 1'b1;
    tick(2);
    chk({7'h0, srq, sbyte}, 16'h0158);
    wr_reg(`SEL_SRQ_ENABLE, 16'h0040);
    tick(1);
    chk({7'h0, srq, sbyte}, 16'h0018);
    // Mid-run reset drops every output and clears the enables
    rstn_in = 1'b0;
    tick(2);
    chk({7'h0, srq, sbyte}, 16'h0000);
    rstn_in = 1'b1;
    rd_reg(`SEL_OPER_ENABLE, 16'h0000);
    rd_reg(`SEL_STB, 16'h0018);
    close_out();
  end
endmodule
